// File: gpio_port_cfg.svh
// offsets, field positions, reset values and timing for the gpio port block
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH

// ****************************************
// register byte addresses
// ****************************************
`define GP_ADDR_W          8
`define GP_OFS_DIRECTION   8'h00
`define GP_OFS_LATCH       8'h04
`define GP_OFS_INPUT       8'h08
`define GP_OFS_ALT_LATCH   8'h0c
`define GP_OFS_CONTROL     8'h10

// ****************************************
// fields and reset values
// ****************************************
`define GP_MODE_BIT        0
`define GP_RST_DIRECTION   8'h00
`define GP_RST_LATCH       8'h00
`define GP_RST_ALT_LATCH   8'h00
`define GP_RST_MODE        1'b0

// ****************************************
// bus answers and timing
// ****************************************
`define GP_RESP_OKAY       2'h0
`define GP_RESP_DECERR     2'h3
`define GP_SYNC_STAGES     2

`endif

// File: gpio_port_pkg.sv
// types shared by the gpio port block
package gpio_port_pkg;

  typedef logic [7:0] port_t;

  typedef enum logic [2:0] {
    SEL_DIRECTION,
    SEL_LATCH,
    SEL_INPUT,
    SEL_ALT_LATCH,
    SEL_CONTROL,
    SEL_NONE
  } reg_sel_e;

endpackage

// File: pin_sync.sv
// two-stage synchroniser for the eight port pins
`timescale 1ns/1ps
module pin_sync
(
  input  wire logic       mclk,
  input  wire logic [7:0] pinIn,
  output logic      [7:0] pinSync
);

  logic [7:0] stageOne;

  // first stage feeds only the second; no reset so no pin value is forced
  always_ff @(posedge mclk)
  begin
    stageOne <= pinIn;
    pinSync  <= stageOne;
  end

endmodule // pin_sync

// File: port_direction_data_regs.sv
// direction and data registers of one gpio port behind an axi4-lite slave
// ****************************************
// Notes on behaviour
// - a direction bit at 1 makes its pin an output, at 0 an input.
// - mode 0 hides the direction register as zero, mode 1 reads it back.
// - the data latch resets to zero, marked bits take the pin level.
// - the data latch holds the value driven on each output pin.
// - a mode 0 latch read gives latch bits for outputs, pins for inputs.
// - with mode 1 a latch read returns the latch for every bit.
// - unimplemented upper bits are reserved: not stored and read as zero.
// - the input level register reads the pins only in mode 1, else zero.
// - the input level register is read-only and ignores writes.
// - a port without a data latch drives pins from the alternate latch.
// ****************************************
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"
module port_direction_data_regs
#(
  parameter logic [7:0] implMask     = 8'hff,
  parameter logic [7:0] pinResetMask = 8'h00,
  parameter bit         hasDataReg   = 1'b1
)
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [7:0]  pinIn,
  output logic [7:0]       pinOut,
  output logic [7:0]       pinOe
);

  // ****************************************
  // state
  // ****************************************
  gpio_port_pkg::port_t pinDirection;
  gpio_port_pkg::port_t outputLatch;
  gpio_port_pkg::port_t altOutputLatch;
  logic                 portsMode;
  gpio_port_pkg::port_t pinSync;
  logic [7:0]           awAddrHeld;
  logic [7:0]           wDataHeld;
  logic                 wLaneHeld;
  logic                 awHeld;
  logic                 wHeld;

  pin_sync u_sync
  (
    .mclk    (mclk),
    .pinIn   (pinIn),
    .pinSync (pinSync)
  );

  // ****************************************
  // decode
  // ****************************************
  gpio_port_pkg::reg_sel_e wSel;
  gpio_port_pkg::reg_sel_e rSel;
  wire [7:0] wAddr = {awAddrHeld[7:2], 2'b00};
  wire [7:0] rAddr = {araddr[7:2], 2'b00};

  always_comb
  begin
    if (wAddr == `GP_OFS_DIRECTION) wSel = gpio_port_pkg::SEL_DIRECTION;
    else if (wAddr == `GP_OFS_LATCH) wSel = gpio_port_pkg::SEL_LATCH;
    else if (wAddr == `GP_OFS_INPUT) wSel = gpio_port_pkg::SEL_INPUT;
    else if (wAddr == `GP_OFS_ALT_LATCH) wSel = gpio_port_pkg::SEL_ALT_LATCH;
    else if (wAddr == `GP_OFS_CONTROL) wSel = gpio_port_pkg::SEL_CONTROL;
    else wSel = gpio_port_pkg::SEL_NONE;
  end

  always_comb
  begin
    if (rAddr == `GP_OFS_DIRECTION) rSel = gpio_port_pkg::SEL_DIRECTION;
    else if (rAddr == `GP_OFS_LATCH) rSel = gpio_port_pkg::SEL_LATCH;
    else if (rAddr == `GP_OFS_INPUT) rSel = gpio_port_pkg::SEL_INPUT;
    else if (rAddr == `GP_OFS_ALT_LATCH) rSel = gpio_port_pkg::SEL_ALT_LATCH;
    else if (rAddr == `GP_OFS_CONTROL) rSel = gpio_port_pkg::SEL_CONTROL;
    else rSel = gpio_port_pkg::SEL_NONE;
  end

  wire doWrite = awHeld && wHeld && !bvalid;
  wire wrOk    = doWrite && wLaneHeld;
  wire [7:0] wrVal = wDataHeld & implMask;
  wire wrDir   = wrOk && (wSel == gpio_port_pkg::SEL_DIRECTION);
  wire wrLatch = wrOk && (wSel == gpio_port_pkg::SEL_LATCH);
  wire wrAlt   = wrOk && (wSel == gpio_port_pkg::SEL_ALT_LATCH);
  wire wrCtl   = wrOk && (wSel == gpio_port_pkg::SEL_CONTROL);
  wire rdTake  = arvalid && arready;

  // ****************************************
  // read mux
  // ****************************************
  // mode 0 mixes latch and live pin per direction bit
  wire [7:0] mixedView = (outputLatch & pinDirection)
                       | (pinSync & ~pinDirection);
  wire [7:0] latchView = portsMode ? outputLatch : mixedView;
  // write-only in mode 0: bit set/clear sequences see zero here
  wire [7:0] dirView   = portsMode ? pinDirection : 8'h00;
  wire [7:0] inView    = portsMode ? pinSync : 8'h00;
  logic [7:0] rdByte;

  always_comb
  begin
    if (rSel == gpio_port_pkg::SEL_DIRECTION) rdByte = dirView;
    else if (rSel == gpio_port_pkg::SEL_LATCH) rdByte = latchView;
    else if (rSel == gpio_port_pkg::SEL_INPUT) rdByte = inView;
    else if (rSel == gpio_port_pkg::SEL_ALT_LATCH) rdByte = altOutputLatch;
    else if (rSel == gpio_port_pkg::SEL_CONTROL) rdByte = {7'h00, portsMode};
    else rdByte = 8'h00;
  end

  wire [7:0] rdMasked = (rSel == gpio_port_pkg::SEL_CONTROL) ? rdByte
                      : (rdByte & implMask);
  wire [7:0] driveSrc = hasDataReg ? outputLatch : altOutputLatch;

  // ****************************************
  // port registers
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pinDirection   <= `GP_RST_DIRECTION;
      // sync reset: marked bits follow the pin level at reset
      outputLatch    <= `GP_RST_LATCH | (pinSync & pinResetMask);
      altOutputLatch <= `GP_RST_ALT_LATCH;
      portsMode      <= `GP_RST_MODE;
    end
    else
    begin
      if (wrDir) pinDirection <= wrVal;
      if (wrLatch) outputLatch <= wrVal;
      if (wrAlt) altOutputLatch <= wrVal;
      if (wrCtl) portsMode <= wDataHeld[`GP_MODE_BIT];
    end
  end

  // one cycle from register to pin, so outputs come straight from flops
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pinOe  <= 8'h00;
      pinOut <= 8'h00;
    end
    else
    begin
      pinOe  <= pinDirection;
      pinOut <= driveSrc;
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      awHeld     <= 1'b0;
      wHeld      <= 1'b0;
      awAddrHeld <= 8'h00;
      wDataHeld  <= 8'h00;
      wLaneHeld  <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `GP_RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awAddrHeld <= awaddr;
        awHeld     <= 1'b1;
        awready    <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wDataHeld <= wdata[7:0];
        wLaneHeld <= wstrb[0];
        wHeld     <= 1'b1;
        wready    <= 1'b0;
      end
      // input level writes are accepted and dropped
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp  <= (wSel == gpio_port_pkg::SEL_NONE) ? `GP_RESP_DECERR
                : `GP_RESP_OKAY;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awHeld  <= 1'b0;
        wHeld   <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `GP_RESP_OKAY;
    end
    else if (rdTake)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, rdMasked};
      rresp   <= (rSel == gpio_port_pkg::SEL_NONE) ? `GP_RESP_DECERR
               : `GP_RESP_OKAY;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  wire rdDir = rdTake && (rSel == gpio_port_pkg::SEL_DIRECTION);
  wire rdDr  = rdTake && (rSel == gpio_port_pkg::SEL_LATCH);
  wire rdPin = rdTake && (rSel == gpio_port_pkg::SEL_INPUT);

  oe_follow_dir_a : assert property (
    ##1 pinOe == $past(pinDirection) )
    else $error("pin enable does not follow direction");
  ddr_hidden_a : assert property (
    rdDir && !portsMode |=> rdata == 32'h0 )
    else $error("direction readable in mode 0");
  ddr_visible_a : assert property ( rdDir && portsMode |=>
    rdata[7:0] == $past(pinDirection) )
    else $error("direction not readable in mode 1");
  latch_reset_a : assert property ( $past(rst) |->
    outputLatch == ($past(pinSync) & pinResetMask) )
    else $error("latch reset value wrong");
  pin_drive_a : assert property ( ##1 pinOut == $past(driveSrc) )
    else $error("pin output not from latch");
  dr_mixed_read_a : assert property ( rdDr && !portsMode |=>
    rdata[7:0] == ($past(mixedView) & implMask) )
    else $error("mode 0 latch read wrong");
  dr_latch_read_a : assert property ( rdDr && portsMode |=>
    rdata[7:0] == ($past(outputLatch) & implMask) )
    else $error("mode 1 latch read wrong");
  reserved_zero_a : assert property (
    ((pinDirection | outputLatch) & ~implMask) == 8'h00 )
    else $error("reserved bit stored");
  pin_gate_a : assert property ( rdPin |=> rdata[7:0] ==
    ($past(portsMode) ? ($past(pinSync) & implMask) : 8'h00) )
    else $error("input level read gated wrongly");
  pin_ro_a : assert property (
    doWrite && wSel == gpio_port_pkg::SEL_INPUT |=>
    $stable(pinDirection) && $stable(outputLatch) )
    else $error("input level write changed state");
  write_resp_a : assert property ( awHeld && wHeld && !bvalid |=> bvalid )
    else $error("write response late");

  write_seen_c : cover property ( wrLatch ##[1:20] rdDr );
  mode_one_c   : cover property ( wrCtl && wDataHeld[`GP_MODE_BIT] );
  input_read_c : cover property ( rdPin && portsMode );

endmodule // port_direction_data_regs

// File: tb_top.sv
// self-checking bench for the gpio port direction and data registers
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"
module tb_top;
  localparam logic [7:0] MASK = 8'h3f;
  logic        mclk;
  logic        rst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [7:0]  pinIn;
  logic [7:0]  pinOut;
  logic [7:0]  pinOe;
  int          nMismatch;
  int          comparisons;
  logic [31:0] lfsr;
  logic [7:0]  dir;
  logic [7:0]  lat;
  logic [7:0]  pin;
  logic        mode;

  // upper two bits left unimplemented so reserved handling is exercised
  port_direction_data_regs #(.implMask(MASK)) u_dut
  (
    .mclk(mclk), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] latchView(input logic m,
    input logic [7:0] d, input logic [7:0] l, input logic [7:0] p);
    return (m ? l : ((l & d) | (p & ~d))) & MASK;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] s, input logic [1:0] expResp);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // ready stays high after the answer so back to back calls never
    // lower and raise it in one time step; only the watchdog ends a wait
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, expResp});
  endtask

  task automatic axiRead(input logic [7:0] a, input logic [7:0] expData,
    input logic [1:0] expResp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    chk(rdata, {24'h000000, expData});
    chk({30'h0, rresp}, {30'h0, expResp});
  endtask

  task automatic printVerdict;
    if (nMismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    nMismatch++;
    printVerdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rst = 1'b1;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    pinIn = 8'h00;
    nMismatch = 0;
    comparisons = 0;
    lfsr = 32'h3b40;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk({pinOe, pinOut}, 16'h0000);
    axiWrite(`GP_OFS_CONTROL, 8'h01, 4'h1, `GP_RESP_OKAY);
    axiRead(`GP_OFS_DIRECTION, 8'h00, `GP_RESP_OKAY);
    axiRead(`GP_OFS_LATCH, 8'h00, `GP_RESP_OKAY);
    // unmapped place: refused both ways
    axiWrite(8'h14, 8'hff, 4'h1, `GP_RESP_DECERR);
    axiRead(8'h14, 8'h00, `GP_RESP_DECERR);
    for (int i = 0; i < 24; i++)
    begin
      lfsr = rnd(lfsr);
      mode = lfsr[0];
      dir = (i == 2) ? 8'hff : lfsr[15:8];
      lat = (i == 3) ? 8'hff : lfsr[23:16];
      pin = lfsr[31:24];
      pinIn <= pin;
      axiWrite(`GP_OFS_CONTROL, {7'h00, mode}, 4'h1, `GP_RESP_OKAY);
      axiWrite(`GP_OFS_DIRECTION, dir, 4'h1, `GP_RESP_OKAY);
      axiWrite(`GP_OFS_LATCH, lat, 4'h1, `GP_RESP_OKAY);
      // strobe off: the latch must keep its value
      axiWrite(`GP_OFS_LATCH, ~lat, 4'h0, `GP_RESP_OKAY);
      axiWrite(`GP_OFS_INPUT, ~pin, 4'h1, `GP_RESP_OKAY);
      axiWrite(`GP_OFS_ALT_LATCH, ~lat, 4'h1, `GP_RESP_OKAY);
      repeat (3) @(posedge mclk);
      chk({24'h0, pinOe}, {24'h0, dir & MASK});
      chk({24'h0, pinOut & pinOe}, {24'h0, lat & dir & MASK});
      axiRead(`GP_OFS_DIRECTION, mode ? dir & MASK : 8'h00,
              `GP_RESP_OKAY);
      axiRead(`GP_OFS_LATCH, latchView(mode, dir, lat, pin),
              `GP_RESP_OKAY);
      axiRead(`GP_OFS_INPUT, mode ? pin & MASK : 8'h00,
              `GP_RESP_OKAY);
      axiRead(`GP_OFS_ALT_LATCH, ~lat & MASK, `GP_RESP_OKAY);
      axiRead(`GP_OFS_CONTROL, {7'h00, mode}, `GP_RESP_OKAY);
    end
    // second reset in mid-run: latch, mode and drivers return to zero
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk({pinOe, pinOut}, 16'h0000);
    axiRead(`GP_OFS_CONTROL, 8'h00, `GP_RESP_OKAY);
    axiRead(`GP_OFS_LATCH, pin & MASK, `GP_RESP_OKAY);
    axiWrite(`GP_OFS_CONTROL, 8'h01, 4'h1, `GP_RESP_OKAY);
    axiRead(`GP_OFS_LATCH, 8'h00, `GP_RESP_OKAY);
    axiRead(`GP_OFS_ALT_LATCH, 8'h00, `GP_RESP_OKAY);
    printVerdict();
  end
endmodule // tb_top
